// ==== pilc_top.v ====
// Purpose: Parallel line controller, 32 lines, AXI4-Lite registers.
// Assumes: Single clock aclk; pads resolved outside from out/oe/pull-up.
// Notes:   Reset levels assume pulled-up pads to avoid false changes.
`timescale 1ns/10ps
`include "pilc_consts.vh"

module pilc_top #(
  parameter [`PILC_NLINES-1:0] ANALOG_MASK = `PILC_ANALOG_DEF
) (
  input  wire                    aclk,
  input  wire                    aresetn,
  input  wire [`PILC_AW-1:0]     s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output reg                     s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output reg                     s_axi_wready,
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  input  wire [`PILC_AW-1:0]     s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output reg                     s_axi_arready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  input  wire [`PILC_NLINES-1:0] pad_in,
  output reg  [`PILC_NLINES-1:0] pad_out_ff,
  output reg  [`PILC_NLINES-1:0] pad_oe_ff,
  output reg  [`PILC_NLINES-1:0] pad_pullup_ff,
  input  wire [`PILC_NLINES-1:0] periph_a_out,
  input  wire [`PILC_NLINES-1:0] periph_a_oe,
  input  wire [`PILC_NLINES-1:0] periph_b_out,
  input  wire [`PILC_NLINES-1:0] periph_b_oe,
  output reg  [`PILC_NLINES-1:0] periph_in_ff,
  input  wire [`PILC_NLINES-1:0] analog_en,
  output reg                     irq_ff
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Byte strobes to a bit mask
  function [31:0] strb_mask;
    input [3:0] strb;
    begin
      strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  // Set/clear update: ones act, zeros leave the line alone
  function [31:0] sc_upd;
    input [31:0] cur;
    input        set_hit;
    input        clr_hit;
    input [31:0] bits;
    begin
      sc_upd = (cur | (set_hit ? bits : 32'h00000000)) &
               ~(clr_hit ? bits : 32'h00000000);
    end
  endfunction

  // --------------------------------------------------------------------
  // Configuration state, one bit per line
  // --------------------------------------------------------------------
  reg  [31:0]          gpen_ff;   // 1 = general-purpose control
  reg  [31:0]          oe_ff;
  reg  [31:0]          filt_ff;
  reg  [31:0]          out_ff;
  reg  [31:0]          ien_ff;
  reg  [31:0]          isr_ff;
  reg  [31:0]          md_ff;
  reg  [31:0]          pu_ff;
  reg  [31:0]          bsel_ff;   // 1 = peripheral B, 0 = peripheral A
  reg  [31:0]          nxt_gpen;
  reg  [31:0]          nxt_oe;
  reg  [31:0]          nxt_filt;
  reg  [31:0]          nxt_out;
  reg  [31:0]          nxt_ien;
  reg  [31:0]          nxt_isr;
  reg  [31:0]          nxt_md;
  reg  [31:0]          nxt_pu;
  reg  [31:0]          nxt_bsel;

  // AXI write and read channel state
  reg                  aw_hold_ff;
  reg  [`PILC_AW-1:0]  awaddr_ff;
  reg                  w_hold_ff;
  reg  [31:0]          wdata_ff;
  reg  [3:0]           wstrb_ff;
  wire                 aw_take;
  wire                 w_take;
  wire                 do_wr;
  wire [31:0]          wbits;
  reg                  wr_hit;
  reg  [31:0]          rd_val;
  reg                  rd_hit;

  wire [31:0]          lvl;
  wire [31:0]          chg_evt;
  reg  [31:0]          nxt_out_pin;
  reg  [31:0]          nxt_oe_pin;

  // --------------------------------------------------------------------
  // Input path
  // --------------------------------------------------------------------
  // Synchronised, optionally filtered level of every pad
  pilc_infilt #(
    .W       (`PILC_NLINES)
  ) pilc_infilt_inst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pad_in  (pad_in),
    .filt_en (filt_ff),
    .lvl_ff  (lvl)
  );

  // Change against the last level handed to peripherals
  assign chg_evt = lvl ^ periph_in_ff;

  // --------------------------------------------------------------------
  // AXI write channel
  // --------------------------------------------------------------------
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  // Write waits for both halves and a free response slot
  assign do_wr   = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
  assign wbits   = wdata_ff & strb_mask(wstrb_ff);

  // Address and data taken in either order, held until the write
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff    <= 1'b0;
      w_hold_ff     <= 1'b0;
      awaddr_ff     <= 8'h00;
      wdata_ff      <= 32'h00000000;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PILC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_ff     <= s_axi_awaddr;
        aw_hold_ff    <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (do_wr) begin
        aw_hold_ff    <= 1'b0;
        s_axi_awready <= 1'b1;
      end
      if (w_take) begin
        wdata_ff     <= s_axi_wdata;
        wstrb_ff     <= s_axi_wstrb;
        w_hold_ff    <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (do_wr) begin
        w_hold_ff    <= 1'b0;
        s_axi_wready <= 1'b1;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `PILC_RESP_OKAY : `PILC_RESP_SLV;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable address decode; status-only words answer with an error
  always @* begin
    case (awaddr_ff)
      `PILC_GPEN_SET, `PILC_GPEN_CLR, `PILC_OE_SET, `PILC_OE_CLR,
      `PILC_FILT_SET, `PILC_FILT_CLR, `PILC_OUT_SET, `PILC_OUT_CLR,
      `PILC_OUT_SYNC, `PILC_IEN_SET, `PILC_IEN_CLR, `PILC_MD_SET,
      `PILC_MD_CLR, `PILC_PU_SET, `PILC_PU_CLR, `PILC_BSEL_SET,
      `PILC_BSEL_CLR, `PILC_ICR: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // Register next values
  // --------------------------------------------------------------------
  // Set/clear pairs; a write touches only lines with a one
  always @* begin
    nxt_gpen = sc_upd(gpen_ff, do_wr & (awaddr_ff == `PILC_GPEN_SET),
                      do_wr & (awaddr_ff == `PILC_GPEN_CLR), wbits);
    nxt_oe   = sc_upd(oe_ff, do_wr & (awaddr_ff == `PILC_OE_SET),
                      do_wr & (awaddr_ff == `PILC_OE_CLR), wbits);
    nxt_filt = sc_upd(filt_ff, do_wr & (awaddr_ff == `PILC_FILT_SET),
                      do_wr & (awaddr_ff == `PILC_FILT_CLR), wbits);
    nxt_ien  = sc_upd(ien_ff, do_wr & (awaddr_ff == `PILC_IEN_SET),
                      do_wr & (awaddr_ff == `PILC_IEN_CLR), wbits);
    nxt_md   = sc_upd(md_ff, do_wr & (awaddr_ff == `PILC_MD_SET),
                      do_wr & (awaddr_ff == `PILC_MD_CLR), wbits);
    nxt_pu   = sc_upd(pu_ff, do_wr & (awaddr_ff == `PILC_PU_SET),
                      do_wr & (awaddr_ff == `PILC_PU_CLR), wbits);
    nxt_bsel = sc_upd(bsel_ff, do_wr & (awaddr_ff == `PILC_BSEL_SET),
                      do_wr & (awaddr_ff == `PILC_BSEL_CLR), wbits);
    nxt_out  = sc_upd(out_ff, do_wr & (awaddr_ff == `PILC_OUT_SET),
                      do_wr & (awaddr_ff == `PILC_OUT_CLR), wbits);
    // Sync write sets and clears the lines of the strobed bytes in one go
    if (do_wr && (awaddr_ff == `PILC_OUT_SYNC))
      nxt_out = (out_ff & ~strb_mask(wstrb_ff)) | wbits;
    // Change event wins over a clear in the same cycle
    nxt_isr = (isr_ff & ~((do_wr && (awaddr_ff == `PILC_ICR)) ?
                          wbits : 32'h00000000)) | chg_evt;
  end

  // Reset: all lines general purpose, input, pulled up
  always @(posedge aclk) begin
    if (!aresetn) begin
      gpen_ff      <= `PILC_ALL_ONES;
      oe_ff        <= `PILC_ALL_ZERO;
      filt_ff      <= `PILC_ALL_ZERO;
      out_ff       <= `PILC_ALL_ZERO;
      ien_ff       <= `PILC_ALL_ZERO;
      isr_ff       <= `PILC_ALL_ZERO;
      md_ff        <= `PILC_ALL_ZERO;
      pu_ff        <= `PILC_ALL_ONES;
      bsel_ff      <= `PILC_ALL_ZERO;
      irq_ff       <= 1'b0;
      periph_in_ff <= `PILC_ALL_ONES;
    end else begin
      gpen_ff      <= nxt_gpen;
      oe_ff        <= nxt_oe;
      filt_ff      <= nxt_filt;
      out_ff       <= nxt_out;
      ien_ff       <= nxt_ien;
      isr_ff       <= nxt_isr;
      md_ff        <= nxt_md;
      pu_ff        <= nxt_pu;
      bsel_ff      <= nxt_bsel;
      irq_ff       <= |(nxt_isr & nxt_ien);
      periph_in_ff <= lvl;
    end
  end

  // --------------------------------------------------------------------
  // Pad drive
  // --------------------------------------------------------------------
  // Owner select, then open-drain and analog overrides per line
  always @* begin
    // General-purpose lines ignore both peripherals
    nxt_out_pin = (gpen_ff & out_ff) |
                  (~gpen_ff & ~bsel_ff & periph_a_out) |
                  (~gpen_ff & bsel_ff & periph_b_out);
    nxt_oe_pin  = (gpen_ff & oe_ff) |
                  (~gpen_ff & ~bsel_ff & periph_a_oe) |
                  (~gpen_ff & bsel_ff & periph_b_oe);
    // Multi-drive: drive low only, float for a high
    nxt_oe_pin  = nxt_oe_pin & ~(md_ff & nxt_out_pin);
    nxt_out_pin = nxt_out_pin & ~md_ff;
    // Analog use frees the pad from digital drive
    nxt_oe_pin  = nxt_oe_pin & ~(analog_en & ANALOG_MASK);
  end

  // No owner check: one peripheral output may drive many lines
  always @(posedge aclk) begin
    if (!aresetn) begin
      pad_out_ff    <= `PILC_ALL_ZERO;
      pad_oe_ff     <= `PILC_ALL_ZERO;
      pad_pullup_ff <= `PILC_ALL_ONES;
    end else begin
      pad_out_ff    <= nxt_out_pin;
      pad_oe_ff     <= nxt_oe_pin;
      pad_pullup_ff <= pu_ff & ~(analog_en & ANALOG_MASK);
    end
  end

  // --------------------------------------------------------------------
  // AXI read channel
  // --------------------------------------------------------------------
  // Read decode; pin level readable whatever the line does
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `PILC_GPEN_STAT: rd_val = gpen_ff;
      `PILC_OE_STAT:   rd_val = oe_ff;
      `PILC_FILT_STAT: rd_val = filt_ff;
      `PILC_OUT_STAT:  rd_val = out_ff;
      `PILC_IEN_STAT:  rd_val = ien_ff;
      `PILC_ISR:       rd_val = isr_ff;
      `PILC_MD_STAT:   rd_val = md_ff;
      `PILC_PU_STAT:   rd_val = pu_ff;
      `PILC_BSEL_STAT: rd_val = bsel_ff;
      `PILC_PDSR:      rd_val = lvl;
      default: begin
        rd_val = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // One read at a time; data held until rready
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PILC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_hit ? `PILC_RESP_OKAY : `PILC_RESP_SLV;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ==== pilc_consts.vh ====
// Purpose: Constants for the parallel line controller (32 lines).
// Assumes: AXI4-Lite register bus, 32-bit data, byte addresses below.
// Notes:   Every register takes one aligned word.
`ifndef PILC_CONSTS_VH
`define PILC_CONSTS_VH

`define PILC_NLINES     32
`define PILC_AW         8

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PILC_GPEN_SET   8'h00
`define PILC_GPEN_CLR   8'h04
`define PILC_GPEN_STAT  8'h08
`define PILC_OE_SET     8'h10
`define PILC_OE_CLR     8'h14
`define PILC_OE_STAT    8'h18
`define PILC_FILT_SET   8'h20
`define PILC_FILT_CLR   8'h24
`define PILC_FILT_STAT  8'h28
`define PILC_OUT_SET    8'h30
`define PILC_OUT_CLR    8'h34
`define PILC_OUT_STAT   8'h38
`define PILC_OUT_SYNC   8'h3C
`define PILC_IEN_SET    8'h40
`define PILC_IEN_CLR    8'h44
`define PILC_IEN_STAT   8'h48
`define PILC_ISR        8'h4C
`define PILC_MD_SET     8'h50
`define PILC_MD_CLR     8'h54
`define PILC_MD_STAT    8'h58
`define PILC_PU_SET     8'h60
`define PILC_PU_CLR     8'h64
`define PILC_PU_STAT    8'h68
`define PILC_BSEL_SET   8'h70
`define PILC_BSEL_CLR   8'h74
`define PILC_BSEL_STAT  8'h78
`define PILC_ICR        8'h80
`define PILC_PDSR       8'h84

// ----------------------------------------------------------------------
// Reset values and default analog line mask
// ----------------------------------------------------------------------
`define PILC_ALL_ONES   32'hFFFFFFFF
`define PILC_ALL_ZERO   32'h00000000
`define PILC_ANALOG_DEF 32'h001E0000

// ----------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------
`define PILC_RESP_OKAY  2'h0
`define PILC_RESP_SLV   2'h2

`endif

// ==== pilc_infilt.v ====
// Purpose: Pin synchroniser and optional per-line glitch filter.
// Assumes: Pins are asynchronous to aclk.
// Notes:   Filtered level changes only after two equal samples.
`timescale 1ns/10ps
`include "pilc_consts.vh"

module pilc_infilt #(
  parameter W = `PILC_NLINES
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] pad_in,
  input  wire [W-1:0] filt_en,
  output reg  [W-1:0] lvl_ff
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  reg [W-1:0] prev_ff;
  reg [W-1:0] nxt_lvl;

  // --------------------------------------------------------------------
  // Filter decision
  // --------------------------------------------------------------------
  // On a filtered line a pulse seen in one sample only never reaches the level
  always @* begin
    nxt_lvl = (~filt_en & sync_ff) |
              (filt_en & ((sync_ff & prev_ff) |
                          (lvl_ff & (sync_ff ^ prev_ff))));
  end

  // Two stages first; the first is read by the second only
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= `PILC_ALL_ONES;
      sync_ff <= `PILC_ALL_ONES;
      prev_ff <= `PILC_ALL_ONES;
      lvl_ff  <= `PILC_ALL_ONES;
    end else begin
      meta_ff <= pad_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
      lvl_ff  <= nxt_lvl;
    end
  end

endmodule

// ==== pilc_top_props.sv ====
// Purpose: Bus and pin timing checks for the line controller.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Sees top ports only; bound at the foot of this file.
`timescale 1ns/10ps
`include "pilc_consts.vh"
module pilc_props #(
  parameter [31:0] ANALOG_MASK = `PILC_ANALOG_DEF
) (
  input wire        aclk,
  input wire        aresetn,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] pad_oe_ff,
  input wire [31:0] pad_pullup_ff,
  input wire [31:0] periph_in_ff,
  input wire [31:0] analog_en,
  input wire        irq_ff
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Transfer steps
  // ----------------------------------------
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Reset state must hold even while reset is low
  property p_reset;
    disable iff (1'h0) !aresetn |=> pad_oe_ff == 32'h0 &&
      pad_pullup_ff == 32'hFFFFFFFF && !irq_ff && !s_axi_bvalid;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_rd_ans;
    s_rd_take |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
  property p_wr_ans;
    s_wr_take |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no write reply");
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("bresp moved");
  property p_rd_bad;
    s_rd_take and s_axi_araddr == 8'hFC |=>
      s_axi_rresp == `PILC_RESP_SLV && s_axi_rdata == 32'h0;
  endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("hole read");
  property p_wr_ro;
    s_wr_take and s_axi_awaddr == `PILC_PDSR |->
      ##[1:2] (s_axi_bvalid && s_axi_bresp == `PILC_RESP_SLV);
  endproperty
  a_wr_ro: assert property (p_wr_ro) else $error("status write ok");
  // Analog request frees the pad one edge later
  property p_analog;
    aresetn |=> ((pad_oe_ff | pad_pullup_ff) & $past(analog_en) &
      ANALOG_MASK) == 32'h0;
  endproperty
  a_analog: assert property (p_analog) else $error("analog pad on");
  // A new interrupt needs a pin change or a register write
  property p_irq;
    $rose(irq_ff) |-> periph_in_ff != $past(periph_in_ff) ||
      s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
endmodule
bind pilc_top pilc_props #(.ANALOG_MASK(ANALOG_MASK)) pilc_props_inst (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_oe_ff, .pad_pullup_ff,
  .periph_in_ff, .analog_en, .irq_ff);

// ==== pilc_pad_model.sv ====
// Purpose: Board model resolving each pin from all of its drivers.
// Assumes: Board drivers are weak; the controller wins a contention.
// Notes:   An undriven pin without pull-up wanders, never holds.
`timescale 1ns/10ps
module pilc_pad_model (
  input  wire         aclk,
  input  wire  [31:0] pad_out_ff,
  input  wire  [31:0] pad_oe_ff,
  input  wire  [31:0] pad_pullup_ff,
  input  wire  [31:0] ext_drv,
  input  wire  [31:0] ext_val,
  output logic [31:0] pad_lvl
);
  logic [31:0] last_ff = 32'h0;
  // Floating pins flip each cycle so a stale level is never trusted
  always @(posedge aclk) begin
    last_ff <= pad_lvl;
  end
  // Controller drive, then board drive, then pull-up, then float
  always @* begin
    for (int i = 0; i < 32; i++) begin
      if (pad_oe_ff[i])
        pad_lvl[i] = pad_out_ff[i];
      else if (ext_drv[i])
        pad_lvl[i] = ext_val[i];
      else if (pad_pullup_ff[i])
        pad_lvl[i] = 1'h1;
      else
        pad_lvl[i] = ~last_ff[i];
    end
  end
endmodule

// ==== pilc_top_test.sv ====
// Purpose: Self-checking bench for the line controller.
// Assumes: Board drives every pin weakly; pads start high.
// Notes:   Register table first, then pins, interrupt, filter, reset.
`timescale 1ns/10ps
`include "pilc_consts.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module pilc_top_test;
  typedef struct packed {
    bit          w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [1:0]  r;
  } pilc_row_t;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, analog_en = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, irq_ff;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, pad_in, pad_out_ff, pad_oe_ff, pad_pullup_ff;
  logic [31:0] periph_in_ff, rdat, ext_val = 32'hFFFFFFFF;
  logic [31:0] ext_drv = 32'hFFFFFFFF;
  logic [31:0] periph_a_out = 32'hFFFFFFFF, periph_a_oe = 32'hFFFFFFFF;
  logic [31:0] periph_b_out = 32'h0000AA00, periph_b_oe = 32'h0000FF00;
  int          bad_count = 0, cmp_count = 0;
  // Set/clear pairs except IEN and BSEL exercised on lines that do not upset later pins
  pilc_row_t   tbl [28] = '{
    '{1, `PILC_OE_SET, 32'hFFFF0000, 2'h0},
    '{0, `PILC_OE_STAT, 32'hFFFF0000, 2'h0},
    '{1, `PILC_OE_CLR, 32'h0F000000, 2'h0},
    '{0, `PILC_OE_STAT, 32'hF0FF0000, 2'h0},
    '{1, `PILC_OUT_SET, 32'h000000FF, 2'h0},
    '{1, `PILC_OUT_CLR, 32'h0000000F, 2'h0},
    '{0, `PILC_OUT_STAT, 32'h000000F0, 2'h0},
    '{1, `PILC_OUT_SYNC, 32'hA5A5A5A5, 2'h0},
    '{0, `PILC_OUT_STAT, 32'hA5A5A5A5, 2'h0},
    '{1, `PILC_FILT_SET, 32'h00000007, 2'h0},
    '{1, `PILC_FILT_CLR, 32'h00000004, 2'h0},
    '{0, `PILC_FILT_STAT, 32'h00000003, 2'h0},
    '{1, `PILC_MD_SET, 32'h30000003, 2'h0},
    '{1, `PILC_MD_CLR, 32'h00000003, 2'h0},
    '{0, `PILC_MD_STAT, 32'h30000000, 2'h0},
    '{1, `PILC_PU_CLR, 32'h0001FFFF, 2'h0},
    '{1, `PILC_PU_SET, 32'h00010000, 2'h0},
    '{0, `PILC_PU_STAT, 32'hFFFF0000, 2'h0},
    '{1, `PILC_BSEL_SET, 32'h0000FF00, 2'h0},
    '{0, `PILC_BSEL_STAT, 32'h0000FF00, 2'h0},
    '{1, `PILC_GPEN_CLR, 32'h0001FF00, 2'h0},
    '{1, `PILC_GPEN_SET, 32'h00010000, 2'h0},
    '{0, `PILC_GPEN_STAT, 32'hFFFF00FF, 2'h0},
    '{0, 8'hFC, 32'h0, 2'h2},
    '{0, `PILC_ICR, 32'h0, 2'h2},
    '{1, `PILC_PDSR, 32'h0, 2'h2},
    '{1, `PILC_ISR, 32'h0, 2'h2},
    '{0, `PILC_IEN_STAT, 32'h0, 2'h0}};

  pilc_top pilc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pad_in, .pad_out_ff, .pad_oe_ff, .pad_pullup_ff, .periph_a_out,
    .periph_a_oe, .periph_b_out, .periph_b_oe, .periph_in_ff, .analog_en,
    .irq_ff);
  pilc_pad_model pilc_pad_model_inst (.aclk, .pad_out_ff, .pad_oe_ff,
    .pad_pullup_ff, .ext_drv, .ext_val, .pad_lvl(pad_in));

  // 125 MHz system clock
  always #4 aclk = ~aclk;

  task automatic conclude;
    $display("mismatches %0d compares %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // A hung handshake is a mismatch and ends the run
  task automatic hang;
    bad_count++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'h0, 1'h1);
    conclude;
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic aw, w;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    aw = 1'h1;
    w = 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        return;
      end
    end
    hang;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        return;
      end
    end
    hang;
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    `CHK(pad_pullup_ff, 32'hFFFFFFFF)
    axi_rd(`PILC_GPEN_STAT, rdat, rs);
    `CHK(rdat, 32'hFFFFFFFF)
    for (int i = 0; i < $size(tbl); i++) begin
      if (tbl[i].w)
        axi_wr(tbl[i].a, tbl[i].d, rs);
      else begin
        axi_rd(tbl[i].a, rdat, rs);
        `CHK(rdat, tbl[i].d)
      end
      `CHK(rs, tbl[i].r)
    end
    // Pins: open drain, owner choice, analog release
    `CHK(pad_oe_ff[31:28], 4'hD)
    `CHK(pad_out_ff[31:28], 4'h8)
    `CHK(pad_out_ff[15:8], 8'hAA)
    `CHK(pad_oe_ff[15:0], 16'hFF00)
    axi_wr(`PILC_BSEL_CLR, 32'h00000F00, rs);
    analog_en <= 32'h00220000;
    repeat (2) @(posedge aclk);
    `CHK(pad_out_ff[15:8], 8'hAF)
    `CHK((pad_oe_ff | pad_pullup_ff) & 32'h00220000, 32'h00200000)
    repeat (8) @(posedge aclk);
    // Interrupt on a GP line and a peripheral line
    axi_wr(`PILC_ICR, 32'hFFFFFFFF, rs);
    axi_rd(`PILC_ISR, rdat, rs);
    `CHK(rdat, 32'h0)
    axi_wr(`PILC_IEN_SET, 32'h00000020, rs);
    ext_val[5] <= 1'h0;
    periph_b_out <= 32'h0000BB00;
    repeat (8) @(posedge aclk);
    `CHK(irq_ff, 1'h1)
    `CHK(periph_in_ff[5], 1'h0)
    axi_rd(`PILC_PDSR, rdat, rs);
    `CHK(rdat[5], 1'h0)
    axi_rd(`PILC_ISR, rdat, rs);
    `CHK(rdat, 32'h00001020)
    axi_wr(`PILC_IEN_CLR, 32'h00000020, rs);
    repeat (2) @(posedge aclk);
    `CHK(irq_ff, 1'h0)
    axi_wr(`PILC_ICR, 32'h00001020, rs);
    // One-cycle glitch: filtered lines 0..1 ignore it, line 2 sees it
    ext_val[2:0] <= 3'h0;
    @(posedge aclk);
    ext_val[2:0] <= 3'h7;
    repeat (8) @(posedge aclk);
    axi_rd(`PILC_ISR, rdat, rs);
    `CHK(rdat, 32'h00000004)
    // Strobed sync write: only byte 0 of the outputs follows the data
    s_axi_wstrb <= 4'h1;
    axi_wr(`PILC_OUT_SYNC, 32'h0000000F, rs);
    s_axi_wstrb <= 4'hF;
    axi_rd(`PILC_OUT_STAT, rdat, rs);
    `CHK(rdat, 32'hA5A5A50F)
    // Board pulls line 24 low, then lets go: the pull-up brings it high
    ext_val[24] <= 1'h0;
    repeat (6) @(posedge aclk);
    axi_rd(`PILC_PDSR, rdat, rs);
    `CHK(rdat[24], 1'h0)
    ext_drv[24] <= 1'h0;
    repeat (6) @(posedge aclk);
    axi_rd(`PILC_PDSR, rdat, rs);
    `CHK(rdat[24], 1'h1)
    // Second reset in mid-run, pads held high
    analog_en <= 32'h0;
    ext_val <= 32'hFFFFFFFF;
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    `CHK(pad_oe_ff, 32'h0)
    axi_rd(`PILC_OE_STAT, rdat, rs);
    `CHK(rdat, 32'h0)
    conclude;
  end
endmodule
